//--- hw/assr_cfg.svh
// Constants for the axis stop and status report block.
// Assumes inclusion by bare name from the design files.
`ifndef ASSR_CFG_SVH
`define ASSR_CFG_SVH
`define ASSR_LVL_DEFAULT 2'h3
`define ASSR_LVL_WARN_BIT 1
`define ASSR_LVL_ERR_BIT 0
`define ASSR_SEL_AMP0 2'h0
`define ASSR_SEL_AMP1 2'h1
`define ASSR_SEL_AMP2 2'h2
`define ASSR_SEL_AMP3 2'h3
`define ASSR_ERR_NONE 8'h00
`define ASSR_CMD_STOP 3'h0
`define ASSR_CMD_LEVEL_WR 3'h1
`define ASSR_CMD_LEVEL_RD 3'h2
`define ASSR_CMD_AMP 3'h3
`define ASSR_CMD_STATUS 3'h4
`define ASSR_CMD_REJECT 3'h5
`define ASSR_SB_PROG 7
`define ASSR_SB_CONTOUR 5
`define ASSR_SB_ERRRTN 4
`define ASSR_SB_INTEN 3
`define ASSR_SB_INTRTN 2
`define ASSR_SB_ECHO 0
`define ASSR_SS_TIMEOUT 0
`define ASSR_SS_CRC 1
`define ASSR_SS_ERR 2
`define ASSR_SS_WARN 3
`endif

//--- hw/assr_pkg.sv
// Types for the axis stop and status report block.
// Assumes the constants header is compiled alongside.
package assr_pkg;
    typedef enum logic [1:0] {
        ASSR_RUN,
        ASSR_DECEL,
        ASSR_HALTED
    } assr_motion_type;
endpackage : assr_pkg

//--- hw/assr_enc_judge.sv
// Judges one encoder's raw error and warning bits against a level code.
// Assumes raw bits synchronous to the controller clock.
`timescale 1ns/1ps
`include "assr_cfg.svh"
module assr_enc_judge (
    input wire logic [1:0] i_level,
    input wire logic i_raw_err,
    input wire logic i_raw_warn,
    input wire logic i_timeout,
    input wire logic i_crc_bad,
    output logic [3:0] o_status,
    output logic o_fault
);
    logic err_act;
    logic warn_act;
    always_comb begin
        err_act = (i_raw_err == i_level[`ASSR_LVL_ERR_BIT]);
        warn_act = (i_raw_warn == i_level[`ASSR_LVL_WARN_BIT]);
        o_status = 4'h0;
        o_status[`ASSR_SS_TIMEOUT] = i_timeout;
        o_status[`ASSR_SS_CRC] = i_crc_bad;
        o_status[`ASSR_SS_ERR] = err_act;
        o_status[`ASSR_SS_WARN] = warn_act;
        o_fault = |o_status;
    end
endmodule : assr_enc_judge

//--- hw/assr_top.sv
// Status and control logic of a single-axis controller: stop, encoder levels,
// amplifier fault bytes, status byte and reject code, over the command port.
// Assumes commands arrive as one-cycle strobes synchronous to I_MCLK.
`timescale 1ns/1ps
`include "assr_cfg.svh"
module assr_top (
    input wire logic I_MCLK,
    input wire logic I_NRST,
    input wire logic i_CMD_VALID,
    input wire logic [2:0] i_CMD_CODE,
    input wire logic i_CMD_AXIS_GIVEN,
    input wire logic i_CMD_AUX_SEL,
    input wire logic [1:0] i_CMD_ARG,
    input wire logic i_BRUSHED_AXIS_SETTING,
    input wire logic i_MAIN_RAW_ERR,
    input wire logic i_MAIN_RAW_WARN,
    input wire logic i_MAIN_TIMEOUT,
    input wire logic i_MAIN_CRC_BAD,
    input wire logic i_AUX_RAW_ERR,
    input wire logic i_AUX_RAW_WARN,
    input wire logic i_AUX_TIMEOUT,
    input wire logic i_AUX_CRC_BAD,
    input wire logic i_UNDER_VOLT,
    input wire logic i_OVER_TEMP,
    input wire logic i_OVER_VOLT,
    input wire logic i_OVER_CURRENT,
    input wire logic i_HALL_INVALID,
    input wire logic i_PEAK_CURRENT,
    input wire logic i_LOCKOUT_ACTIVE_FLAG,
    input wire logic i_PROG_START,
    input wire logic i_CONTOURING,
    input wire logic i_ERR_ROUTINE,
    input wire logic i_INT_ENABLED,
    input wire logic i_INT_ROUTINE,
    input wire logic i_ECHO_ON,
    input wire logic i_REJECT_VALID,
    input wire logic [7:0] i_REJECT_CODE,
    input wire logic i_DECEL_DONE,
    output logic o_RSP_VALID,
    output logic [7:0] o_RSP_DATA,
    output logic o_RSP_MSG,
    output logic o_DECEL_ACTIVE,
    output logic o_MOTION_HALTED,
    output logic o_PROG_RUNNING,
    output logic o_AXIS_DISABLE,
    output logic [3:0] o_MAIN_FAULT_STATUS,
    output logic [3:0] o_AUX_FAULT_STATUS,
    output logic o_SERIAL_ENCODER_FAULT_EVENT
);
    logic rst_meta_r;
    logic rst_sync_r;
    logic rst_n;

    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
    assign rst_n = rst_sync_r;

    logic cmd_stop;
    logic cmd_lvl_wr;
    assign cmd_stop = i_CMD_VALID && (i_CMD_CODE == `ASSR_CMD_STOP);
    assign cmd_lvl_wr = i_CMD_VALID && (i_CMD_CODE == `ASSR_CMD_LEVEL_WR);

    // Motion and program state
    assr_pkg::assr_motion_type motion_r;
    assr_pkg::assr_motion_type motion_nxt;
    logic prog_r;
    logic prog_nxt;

    always_comb begin
        motion_nxt = motion_r;
        prog_nxt = prog_r;
        if (i_PROG_START) begin
            prog_nxt = 1'b1;
        end
        case (motion_r)
            assr_pkg::ASSR_RUN: begin
                if (cmd_stop) begin
                    motion_nxt = assr_pkg::ASSR_DECEL;
                end
            end
            assr_pkg::ASSR_DECEL: begin
                if (i_DECEL_DONE) begin
                    motion_nxt = assr_pkg::ASSR_HALTED;
                end
            end
            assr_pkg::ASSR_HALTED: begin
                if (i_PROG_START) begin
                    motion_nxt = assr_pkg::ASSR_RUN;
                end
            end
            default: begin
                motion_nxt = assr_pkg::ASSR_RUN;
            end
        endcase
        if (cmd_stop && !i_CMD_AXIS_GIVEN) begin
            prog_nxt = 1'b0;
        end
    end

    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            motion_r <= assr_pkg::ASSR_RUN;
            prog_r <= 1'b0;
        end else begin
            motion_r <= motion_nxt;
            prog_r <= prog_nxt;
        end
    end

    // Encoder level settings
    logic [1:0] lvl_main_r;
    logic [1:0] lvl_main_nxt;
    logic [1:0] lvl_aux_r;
    logic [1:0] lvl_aux_nxt;

    always_comb begin
        lvl_main_nxt = lvl_main_r;
        lvl_aux_nxt = lvl_aux_r;
        if (cmd_lvl_wr && i_CMD_AUX_SEL) begin
            lvl_aux_nxt = i_CMD_ARG;
        end else if (cmd_lvl_wr) begin
            lvl_main_nxt = i_CMD_ARG;
        end
    end

    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            lvl_main_r <= `ASSR_LVL_DEFAULT;
            lvl_aux_r <= `ASSR_LVL_DEFAULT;
        end else begin
            lvl_main_r <= lvl_main_nxt;
            lvl_aux_r <= lvl_aux_nxt;
        end
    end

    logic [3:0] main_stat;
    logic [3:0] aux_stat;
    logic main_fault;
    logic aux_fault;

    assr_enc_judge u_main_judge (
        .i_level(lvl_main_r),
        .i_raw_err(i_MAIN_RAW_ERR),
        .i_raw_warn(i_MAIN_RAW_WARN),
        .i_timeout(i_MAIN_TIMEOUT),
        .i_crc_bad(i_MAIN_CRC_BAD),
        .o_status(main_stat),
        .o_fault(main_fault)
    );

    assr_enc_judge u_aux_judge (
        .i_level(lvl_aux_r),
        .i_raw_err(i_AUX_RAW_ERR),
        .i_raw_warn(i_AUX_RAW_WARN),
        .i_timeout(i_AUX_TIMEOUT),
        .i_crc_bad(i_AUX_CRC_BAD),
        .o_status(aux_stat),
        .o_fault(aux_fault)
    );

    // Fault status and event
    logic [3:0] main_ss_r;
    logic [3:0] aux_ss_r;
    logic any_fault_r;
    logic fault_evt_r;
    logic fault_evt_nxt;

    always_comb begin
        fault_evt_nxt = (main_fault || aux_fault) && !any_fault_r;
    end

    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            main_ss_r <= 4'h0;
            aux_ss_r <= 4'h0;
            any_fault_r <= 1'b0;
            fault_evt_r <= 1'b0;
        end else begin
            main_ss_r <= main_stat;
            aux_ss_r <= aux_stat;
            any_fault_r <= main_fault || aux_fault;
            fault_evt_r <= fault_evt_nxt;
        end
    end

    // Amplifier and controller status bytes
    logic [7:0] amp0;
    logic [7:0] amp1;
    logic [7:0] amp2;
    logic [7:0] amp3;
    logic [7:0] stat_byte;
    logic hall_err;

    always_comb begin
        hall_err = i_HALL_INVALID && !i_BRUSHED_AXIS_SETTING;
        amp0 = {4'h0, i_UNDER_VOLT, i_OVER_TEMP, i_OVER_VOLT, i_OVER_CURRENT};
        amp1 = {7'h00, hall_err};
        amp2 = {7'h00, i_PEAK_CURRENT};
        amp3 = {7'h00, i_LOCKOUT_ACTIVE_FLAG};
        stat_byte = 8'h00;
        stat_byte[`ASSR_SB_PROG] = prog_r;
        stat_byte[`ASSR_SB_CONTOUR] = i_CONTOURING;
        stat_byte[`ASSR_SB_ERRRTN] = i_ERR_ROUTINE;
        stat_byte[`ASSR_SB_INTEN] = i_INT_ENABLED;
        stat_byte[`ASSR_SB_INTRTN] = i_INT_ROUTINE;
        stat_byte[`ASSR_SB_ECHO] = i_ECHO_ON;
    end

    // Reject code
    logic [7:0] reject_r;
    logic [7:0] reject_nxt;

    always_comb begin
        reject_nxt = reject_r;
        if (i_REJECT_VALID && (i_REJECT_CODE != `ASSR_ERR_NONE)) begin
            reject_nxt = i_REJECT_CODE;
        end
    end

    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            reject_r <= `ASSR_ERR_NONE;
        end else begin
            reject_r <= reject_nxt;
        end
    end

    // Response path
    logic rsp_valid_r;
    logic rsp_valid_nxt;
    logic [7:0] rsp_data_r;
    logic [7:0] rsp_data_nxt;
    logic rsp_msg_r;
    logic rsp_msg_nxt;

    always_comb begin
        rsp_valid_nxt = 1'b0;
        rsp_data_nxt = rsp_data_r;
        rsp_msg_nxt = 1'b0;
        if (i_CMD_VALID) begin
            case (i_CMD_CODE)
                `ASSR_CMD_LEVEL_RD: begin
                    rsp_valid_nxt = 1'b1;
                    rsp_data_nxt = {6'h00, i_CMD_AUX_SEL ? lvl_aux_r : lvl_main_r};
                end
                `ASSR_CMD_AMP: begin
                    rsp_valid_nxt = 1'b1;
                    case (i_CMD_ARG)
                        `ASSR_SEL_AMP0: rsp_data_nxt = amp0;
                        `ASSR_SEL_AMP1: rsp_data_nxt = amp1;
                        `ASSR_SEL_AMP2: rsp_data_nxt = amp2;
                        default: rsp_data_nxt = amp3;
                    endcase
                end
                `ASSR_CMD_STATUS: begin
                    rsp_valid_nxt = 1'b1;
                    rsp_data_nxt = stat_byte;
                end
                `ASSR_CMD_REJECT: begin
                    rsp_valid_nxt = 1'b1;
                    rsp_data_nxt = reject_r;
                    rsp_msg_nxt = i_CMD_ARG[0];
                end
                default: begin
                    rsp_valid_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid_r <= 1'b0;
            rsp_data_r <= 8'h00;
            rsp_msg_r <= 1'b0;
        end else begin
            rsp_valid_r <= rsp_valid_nxt;
            rsp_data_r <= rsp_data_nxt;
            rsp_msg_r <= rsp_msg_nxt;
        end
    end

    assign o_RSP_VALID = rsp_valid_r;
    assign o_RSP_DATA = rsp_data_r;
    assign o_RSP_MSG = rsp_msg_r;
    assign o_DECEL_ACTIVE = (motion_r == assr_pkg::ASSR_DECEL);
    assign o_MOTION_HALTED = (motion_r == assr_pkg::ASSR_HALTED);
    assign o_PROG_RUNNING = prog_r;
    assign o_AXIS_DISABLE = hall_err;
    assign o_MAIN_FAULT_STATUS = main_ss_r;
    assign o_AUX_FAULT_STATUS = aux_ss_r;
    assign o_SERIAL_ENCODER_FAULT_EVENT = fault_evt_r;
endmodule : assr_top

//--- verification/assr_top_asserts.sv
// Checker for the command port, stop sequence and fault outputs.
// Assumes it is bound onto assr_top with one clock domain.
`timescale 1ns/1ps
`include "assr_cfg.svh"
module assr_top_asserts (
    input wire logic I_MCLK,
    input wire logic I_NRST,
    input wire logic i_CMD_VALID,
    input wire logic [2:0] i_CMD_CODE,
    input wire logic i_CMD_AXIS_GIVEN,
    input wire logic [1:0] i_CMD_ARG,
    input wire logic i_BRUSHED_AXIS_SETTING,
    input wire logic i_HALL_INVALID,
    input wire logic i_CONTOURING,
    input wire logic i_ECHO_ON,
    input wire logic i_DECEL_DONE,
    input wire logic o_RSP_VALID,
    input wire logic [7:0] o_RSP_DATA,
    input wire logic o_RSP_MSG,
    input wire logic o_DECEL_ACTIVE,
    input wire logic o_MOTION_HALTED,
    input wire logic o_PROG_RUNNING,
    input wire logic o_AXIS_DISABLE,
    input wire logic [3:0] o_MAIN_FAULT_STATUS,
    input wire logic [3:0] o_AUX_FAULT_STATUS,
    input wire logic o_SERIAL_ENCODER_FAULT_EVENT
);
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_NRST);
    property p_hall_byte;
        i_CMD_VALID && i_CMD_CODE == `ASSR_CMD_AMP && i_CMD_ARG == `ASSR_SEL_AMP1
        |=> o_RSP_VALID
        && o_RSP_DATA == {7'h00, $past(i_HALL_INVALID && !i_BRUSHED_AXIS_SETTING)};
    endproperty
    a_hall_byte: assert property (p_hall_byte) else $error("hall byte wrong");
    property p_status;
        i_CMD_VALID && i_CMD_CODE == `ASSR_CMD_STATUS |=> o_RSP_VALID && o_RSP_DATA[6] == 1'b0
        && o_RSP_DATA[1] == 1'b0 && o_RSP_DATA[5] == $past(i_CONTOURING)
        && o_RSP_DATA[0] == $past(i_ECHO_ON);
    endproperty
    a_status: assert property (p_status) else $error("status byte wrong");
    property p_quiet;
        !(i_CMD_VALID && i_CMD_CODE inside {[2:5]}) |=> !o_RSP_VALID;
    endproperty
    a_quiet: assert property (p_quiet) else $error("answer without query");
    property p_msg;
        i_CMD_VALID && i_CMD_CODE == `ASSR_CMD_REJECT |=> o_RSP_VALID && o_RSP_MSG == $past(i_CMD_ARG[0]);
    endproperty
    a_msg: assert property (p_msg) else $error("message flag wrong");
    property p_disable;
        o_AXIS_DISABLE == (i_HALL_INVALID && !i_BRUSHED_AXIS_SETTING);
    endproperty
    a_disable: assert property (p_disable) else $error("axis disable wrong");
    property p_stop;
        i_CMD_VALID && i_CMD_CODE == `ASSR_CMD_STOP && !o_DECEL_ACTIVE && !o_MOTION_HALTED
        |=> o_DECEL_ACTIVE && !o_MOTION_HALTED;
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not ramp");
    property p_general;
        i_CMD_VALID && i_CMD_CODE == `ASSR_CMD_STOP && !i_CMD_AXIS_GIVEN |=> !o_PROG_RUNNING;
    endproperty
    a_general: assert property (p_general) else $error("program kept running");
    property p_halt;
        o_DECEL_ACTIVE && i_DECEL_DONE |=> o_MOTION_HALTED && !o_DECEL_ACTIVE;
    endproperty
    a_halt: assert property (p_halt) else $error("ramp did not end");
    property p_event;
        $rose(|{o_MAIN_FAULT_STATUS, o_AUX_FAULT_STATUS}) |-> o_SERIAL_ENCODER_FAULT_EVENT;
    endproperty
    a_event: assert property (p_event) else $error("fault event missing");
    c_halt: cover property (o_DECEL_ACTIVE ##1 o_MOTION_HALTED);
    c_event: cover property (o_SERIAL_ENCODER_FAULT_EVENT);
    c_msg: cover property (o_RSP_VALID && o_RSP_MSG);
endmodule : assr_top_asserts
bind assr_top assr_top_asserts u_chk (.I_MCLK, .I_NRST, .i_CMD_VALID, .i_CMD_CODE,
    .i_CMD_AXIS_GIVEN, .i_CMD_ARG, .i_BRUSHED_AXIS_SETTING, .i_HALL_INVALID, .i_CONTOURING,
    .i_ECHO_ON, .i_DECEL_DONE, .o_RSP_VALID, .o_RSP_DATA, .o_RSP_MSG, .o_DECEL_ACTIVE,
    .o_MOTION_HALTED, .o_PROG_RUNNING, .o_AXIS_DISABLE, .o_MAIN_FAULT_STATUS,
    .o_AUX_FAULT_STATUS, .o_SERIAL_ENCODER_FAULT_EVENT);

//--- verification/assr_host_model.sv
// Host model: sends one command strobe at a time on the command port.
// Assumes the device takes commands on the rising clock edge.
`timescale 1ns/1ps
module assr_host_model (
    input wire logic i_clk,
    output logic o_valid,
    output logic [2:0] o_code,
    output logic o_axis,
    output logic o_aux,
    output logic [1:0] o_arg
);
    initial begin
        o_valid = 1'b0;
        o_code = 3'h7;
        o_axis = 1'b0;
        o_aux = 1'b0;
        o_arg = 2'h0;
    end
    // Code and argument fields show the inverse while no command is held
    task automatic issue(input logic [2:0] c, input logic ax, input logic au, input logic [1:0] a);
        @(negedge i_clk);
        o_valid = 1'b1;
        o_code = c;
        o_axis = ax;
        o_aux = au;
        o_arg = a;
        @(negedge i_clk);
        o_valid = 1'b0;
        o_code = ~c;
        o_arg = ~a;
    endtask : issue
endmodule : assr_host_model

//--- verification/assr_top_bench.sv
// Bench for assr_top: command sequences with expected answers.
// Assumes the host model drives the command port.
`timescale 1ns/1ps
`include "assr_cfg.svh"
module assr_top_bench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic brushed = 1'b0;
    logic [3:0] me = 4'h0;
    logic [3:0] ae = 4'h0;
    logic [6:0] amp = 7'h00;
    logic [4:0] sts = 5'h00;
    logic pstart = 1'b0;
    logic rej_v = 1'b0;
    logic [7:0] rej_c = 8'h00;
    logic dd = 1'b0;
    logic cv, cax, caux, rv, rmsg, decel, halted, prog, dis, evt;
    logic [2:0] cc;
    logic [1:0] carg;
    logic [7:0] rd_data, got;
    logic [3:0] mfs, afs;
    logic gmsg;
    int fail_count = 0;
    int comparisons = 0;
    int k;
    always #20 clk = ~clk;
    assr_host_model host (.i_clk(clk), .o_valid(cv), .o_code(cc), .o_axis(cax), .o_aux(caux),
        .o_arg(carg));
    assr_top uut (.I_MCLK(clk), .I_NRST(nrst), .i_CMD_VALID(cv), .i_CMD_CODE(cc),
        .i_CMD_AXIS_GIVEN(cax), .i_CMD_AUX_SEL(caux), .i_CMD_ARG(carg),
        .i_BRUSHED_AXIS_SETTING(brushed), .i_MAIN_RAW_ERR(me[2]), .i_MAIN_RAW_WARN(me[3]),
        .i_MAIN_TIMEOUT(me[0]), .i_MAIN_CRC_BAD(me[1]), .i_AUX_RAW_ERR(ae[2]),
        .i_AUX_RAW_WARN(ae[3]), .i_AUX_TIMEOUT(ae[0]), .i_AUX_CRC_BAD(ae[1]),
        .i_UNDER_VOLT(amp[6]), .i_OVER_TEMP(amp[5]), .i_OVER_VOLT(amp[4]),
        .i_OVER_CURRENT(amp[3]), .i_HALL_INVALID(amp[2]), .i_PEAK_CURRENT(amp[1]),
        .i_LOCKOUT_ACTIVE_FLAG(amp[0]), .i_PROG_START(pstart), .i_CONTOURING(sts[4]),
        .i_ERR_ROUTINE(sts[3]), .i_INT_ENABLED(sts[2]), .i_INT_ROUTINE(sts[1]),
        .i_ECHO_ON(sts[0]), .i_REJECT_VALID(rej_v), .i_REJECT_CODE(rej_c), .i_DECEL_DONE(dd),
        .o_RSP_VALID(rv), .o_RSP_DATA(rd_data), .o_RSP_MSG(rmsg), .o_DECEL_ACTIVE(decel),
        .o_MOTION_HALTED(halted), .o_PROG_RUNNING(prog), .o_AXIS_DISABLE(dis),
        .o_MAIN_FAULT_STATUS(mfs), .o_AUX_FAULT_STATUS(afs),
        .o_SERIAL_ENCODER_FAULT_EVENT(evt));
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Query and wait a bounded time for the answer
    task automatic rd(input logic [2:0] c, input logic au, input logic [1:0] a);
        int i;
        host.issue(c, 1'b0, au, a);
        for (i = 0; i < 4 && rv !== 1'b1; i++) @(negedge clk);
        if (rv !== 1'b1) begin
            fail_count++;
            stop_test();
        end else begin
            got = rd_data;
            gmsg = rmsg;
        end
    endtask : rd
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask : pulse
    initial begin
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        rd(`ASSR_CMD_LEVEL_RD, 1'b1, 2'h0);
        chk(got, 8'h03);
        me = 4'h4;
        for (k = 0; k < 4; k++) begin
            host.issue(`ASSR_CMD_LEVEL_WR, 1'b0, 1'b0, 2'(k));
            rd(`ASSR_CMD_LEVEL_RD, 1'b0, 2'h0);
            chk(got, 8'(k));
            chk({4'h0, mfs}, {4'h0, ~k[1], k[0], 2'b00});
        end
        rd(`ASSR_CMD_LEVEL_RD, 1'b1, 2'h0);
        chk(got, 8'h03);
        me = 4'h0;
        repeat (2) @(negedge clk);
        ae = 4'hB;
        @(negedge clk);
        chk({evt, afs}, 8'h1B);
        @(negedge clk);
        chk({7'h00, evt}, 8'h00);
        for (k = 0; k < 8; k++) begin
            amp = k[2] ? 7'h29 : 7'h56;
            rd(`ASSR_CMD_AMP, 1'b0, 2'(k));
            chk(got, k[1:0] == 2'h0 ? {4'h0, amp[6:3]} : {7'h00, amp[3 - k[1:0]]});
            chk({7'h00, dis}, {7'h00, amp[2]});
        end
        amp = 7'h56;
        brushed = 1'b1;
        @(negedge clk);
        chk({7'h00, dis}, 8'h00);
        pulse(pstart);
        for (k = 0; k < 2; k++) begin
            sts = k[0] ? 5'h0A : 5'h15;
            rd(`ASSR_CMD_STATUS, 1'b0, 2'h0);
            chk(got, {2'b10, sts[4:1], 1'b0, sts[0]});
        end
        rej_c = 8'h2A;
        pulse(rej_v);
        rd(`ASSR_CMD_REJECT, 1'b0, 2'h1);
        chk({gmsg, got[6:0]}, 8'hAA);
        rej_c = 8'h00;
        pulse(rej_v);
        rd(`ASSR_CMD_REJECT, 1'b0, 2'h0);
        chk({gmsg, got[6:0]}, 8'h2A);
        host.issue(`ASSR_CMD_STOP, 1'b1, 1'b0, 2'h0);
        @(negedge clk);
        chk({decel, halted, prog}, 8'h05);
        pulse(dd);
        @(negedge clk);
        chk({decel, halted, prog}, 8'h03);
        pulse(pstart);
        host.issue(`ASSR_CMD_STOP, 1'b0, 1'b0, 2'h0);
        @(negedge clk);
        chk({decel, prog}, 8'h02);
        rd(`ASSR_CMD_STATUS, 1'b0, 2'h0);
        chk({7'h00, got[7]}, 8'h00);
        pulse(dd);
        host.issue(3'h7, 1'b0, 1'b0, 2'h0);
        chk({7'h00, rv}, 8'h00);
        stop_test();
    end
endmodule : assr_top_bench
